//--- core/psm_ctl.sv
// execution control: isa mode, bundle issue, predicates, speculation checks
`timescale 1ns/1ns
`include "psm_regs.svh"

module psm_ctl
	import psm_pkg::*;
(
	input  wire logic                            SYS_CLK,
	input  wire logic                            RST,
	input  wire logic                            GROUP_VALID,
	input  wire logic [`PSM_ADDR_W-1:0]          GROUP_PC,
	input  wire psm_bundle_t [`PSM_BUNDLES-1:0]  GROUP,
	input  wire logic                            INT_REQ,
	input  wire logic [`PSM_ADDR_W-1:0]          INT_VECTOR,
	output logic                                 NATIVE_MODE,
	output logic                                 REDIRECT_VALID,
	output logic [`PSM_ADDR_W-1:0]               REDIRECT_PC,
	output logic                                 INT_ACK,
	output logic [1:0]                           ISSUE_COUNT,
	output logic [`PSM_GROUP_SLOTS-1:0]          WB_EN,
	output psm_mem_req_t [`PSM_GROUP_SLOTS-1:0]  MEM_REQ,
	output logic [`PSM_PR_COUNT-1:0]             PRED
);

	// architectural state
	psm_isa_t                        mode;
	logic [`PSM_PR_COUNT-1:0]        pred;
	logic [`PSM_GR_COUNT-1:0]        nat_gr;
	logic [`PSM_FR_COUNT-1:0]        nat_fr;
	logic [`PSM_ADDR_W-1:0]          br_reg [`PSM_BR_COUNT];
	logic [`PSM_ADDR_W-1:0]          save_pc;
	psm_isa_t                        save_mode;
	logic                            alat_valid [`PSM_ALAT_ENTRIES];
	logic [`PSM_REG_IDX_W:0]         alat_key [`PSM_ALAT_ENTRIES];
	logic [`PSM_ADDR_W-1:0]          alat_addr [`PSM_ALAT_ENTRIES];
	logic [`PSM_ALAT_IDX_W-1:0]      alat_ptr;

	// next values
	psm_isa_t                        next_mode;
	logic [`PSM_PR_COUNT-1:0]        next_pred;
	logic [`PSM_GR_COUNT-1:0]        next_nat_gr;
	logic [`PSM_FR_COUNT-1:0]        next_nat_fr;
	logic                            next_br_we;
	logic [`PSM_BR_IDX_W-1:0]        next_br_sel;
	logic [`PSM_ADDR_W-1:0]          next_br_val;
	logic                            next_save_we;
	logic [`PSM_ADDR_W-1:0]          next_save_pc;
	psm_isa_t                        next_save_mode;
	logic                            next_alat_valid [`PSM_ALAT_ENTRIES];
	logic [`PSM_REG_IDX_W:0]         next_alat_key [`PSM_ALAT_ENTRIES];
	logic [`PSM_ADDR_W-1:0]          next_alat_addr [`PSM_ALAT_ENTRIES];
	logic [`PSM_ALAT_IDX_W-1:0]      next_alat_ptr;
	logic                            next_redirect;
	logic [`PSM_ADDR_W-1:0]          next_redirect_pc;
	logic                            next_int_ack;
	logic [1:0]                      next_issue;
	logic [`PSM_GROUP_SLOTS-1:0]     next_wb;
	psm_mem_req_t [`PSM_GROUP_SLOTS-1:0] next_mem;

	// per-slot working values of the combinational walk
	psm_slot_t                       sl;
	logic                            take;
	logic                            qt;
	logic                            killed;
	logic                            bundle_used;
	logic                            hit;
	logic [`PSM_REG_IDX_W:0]         key;
	logic [`PSM_ALAT_IDX_W-1:0]      slot_sel;
	int                              idx;

	function automatic logic [`PSM_PR_COUNT-1:0] pred_write(
		input logic [`PSM_PR_COUNT-1:0]  v,
		input logic [`PSM_PR_IDX_W-1:0]  i,
		input logic                      b
	);
		logic [`PSM_PR_COUNT-1:0] r;
		r = v;
		// predicate zero reads as true and ignores writes
		if (i != '0) begin
			r[i] = b;
		end
		return r;
	endfunction : pred_write

	function automatic logic [`PSM_ADDR_W-`PSM_LINE_LSB-1:0] line_of(
		input logic [`PSM_ADDR_W-1:0] a
	);
		return a[`PSM_ADDR_W-1:`PSM_LINE_LSB];
	endfunction : line_of

	function automatic psm_mem_req_t mem_of(input psm_slot_t s, input logic st);
		psm_mem_req_t m;
		m.valid = 1'h1;
		m.store = st;
		m.hint  = s.hint;
		m.addr  = s.addr;
		return m;
	endfunction : mem_of

	always_comb begin
		next_mode        = mode;
		next_pred        = pred;
		next_nat_gr      = nat_gr;
		next_nat_fr      = nat_fr;
		next_br_we       = 1'h0;
		next_br_sel      = '0;
		next_br_val      = '0;
		next_save_we     = 1'h0;
		next_save_pc     = save_pc;
		next_save_mode   = save_mode;
		next_alat_valid  = alat_valid;
		next_alat_key    = alat_key;
		next_alat_addr   = alat_addr;
		next_alat_ptr    = alat_ptr;
		next_redirect    = 1'h0;
		next_redirect_pc = '0;
		next_int_ack     = 1'h0;
		next_issue       = 2'h0;
		next_wb          = '0;
		next_mem         = '0;
		sl               = '0;
		take             = 1'h0;
		qt               = 1'h0;
		killed           = 1'h0;
		bundle_used      = 1'h0;
		hit              = 1'h0;
		key              = '0;
		slot_sel         = '0;
		idx              = 0;
		if (INT_REQ) begin
			// interrupt wins over the whole group; the group is replayed after return
			next_save_we     = 1'h1;
			next_save_pc     = GROUP_PC;
			next_save_mode   = mode;
			next_mode        = ISA_NATIVE;
			next_redirect    = 1'h1;
			next_redirect_pc = INT_VECTOR;
			next_int_ack     = 1'h1;
		end else if (GROUP_VALID) begin
			for (int b = 0; b < `PSM_BUNDLES; b++) begin
				bundle_used = 1'h0;
				for (int s = 0; s < `PSM_SLOTS; s++) begin
					idx = b * `PSM_SLOTS + s;
					sl  = GROUP[b].slot[s];
					// legacy code runs one instruction per cycle, in slot zero
					take = sl.valid && !killed && (mode == ISA_NATIVE || idx == 0);
					qt   = (mode == ISA_LEGACY) || sl.qp == '0 || next_pred[sl.qp];
					key  = {sl.fp, sl.dst};
					if (take) begin
						bundle_used = 1'h1;
						unique case (sl.op)
							OP_NOP: begin
							end
							OP_ALU: begin
								if (qt) begin
									next_wb[idx] = 1'h1;
									if (sl.fp) begin
										next_nat_fr[sl.dst] = 1'h0;
									end else begin
										next_nat_gr[sl.dst] = 1'h0;
									end
								end
							end
							OP_LD, OP_LD_SPEC, OP_LD_ADV: begin
								if (qt) begin
									next_wb[idx]  = 1'h1;
									next_mem[idx] = mem_of(sl, 1'h0);
									// a speculative fault marks the target instead of trapping
									if (sl.fp) begin
										next_nat_fr[sl.dst] = (sl.op == OP_LD_SPEC) && sl.fault;
									end else begin
										next_nat_gr[sl.dst] = (sl.op == OP_LD_SPEC) && sl.fault;
									end
									if (sl.op == OP_LD_ADV) begin
										slot_sel = next_alat_ptr;
										hit      = 1'h0;
										for (int e = 0; e < `PSM_ALAT_ENTRIES; e++) begin
											if (!hit && next_alat_valid[e] && next_alat_key[e] == key) begin
												slot_sel = e[`PSM_ALAT_IDX_W-1:0];
												hit      = 1'h1;
											end
										end
										next_alat_valid[slot_sel] = 1'h1;
										next_alat_key[slot_sel]   = key;
										next_alat_addr[slot_sel]  = sl.addr;
										if (!hit) begin
											next_alat_ptr = next_alat_ptr + 3'h1;
										end
									end
								end
							end
							OP_ST: begin
								if (qt) begin
									next_mem[idx] = mem_of(sl, 1'h1);
									// overlap at line granularity: conservative, may recover needlessly
									for (int e = 0; e < `PSM_ALAT_ENTRIES; e++) begin
										if (line_of(next_alat_addr[e]) == line_of(sl.addr)) begin
											next_alat_valid[e] = 1'h0;
										end
									end
								end
							end
							OP_CMP: begin
								if (qt && mode == ISA_NATIVE) begin
									next_pred = pred_write(next_pred, sl.true_predicate, sl.cond);
									next_pred = pred_write(next_pred, sl.false_predicate, !sl.cond);
								end
							end
							OP_CMP_UNC: begin
								if (mode == ISA_NATIVE) begin
									// a false qualifier still clears both targets
									next_pred = pred_write(next_pred, sl.true_predicate, qt && sl.cond);
									next_pred = pred_write(next_pred, sl.false_predicate, qt && !sl.cond);
								end
							end
							OP_CMP_AND: begin
								if (qt && !sl.cond && mode == ISA_NATIVE) begin
									next_pred = pred_write(next_pred, sl.true_predicate, 1'h0);
									next_pred = pred_write(next_pred, sl.false_predicate, 1'h0);
								end
							end
							OP_CMP_OR: begin
								if (qt && sl.cond && mode == ISA_NATIVE) begin
									next_pred = pred_write(next_pred, sl.true_predicate, 1'h1);
									next_pred = pred_write(next_pred, sl.false_predicate, 1'h1);
								end
							end
							OP_CHK_S: begin
								if (qt && mode == ISA_NATIVE &&
								    (sl.fp ? next_nat_fr[sl.dst] : next_nat_gr[sl.dst])) begin
									next_redirect    = 1'h1;
									next_redirect_pc = sl.addr;
									killed           = 1'h1;
								end
							end
							OP_CHK_A: begin
								hit = 1'h0;
								for (int e = 0; e < `PSM_ALAT_ENTRIES; e++) begin
									if (next_alat_valid[e] && next_alat_key[e] == key) begin
										hit = 1'h1;
									end
								end
								if (qt && mode == ISA_NATIVE && !hit) begin
									next_redirect    = 1'h1;
									next_redirect_pc = sl.addr;
									killed           = 1'h1;
								end
							end
							OP_BR_LEGACY: begin
								if (qt && mode == ISA_NATIVE) begin
									next_mode        = ISA_LEGACY;
									next_redirect    = 1'h1;
									next_redirect_pc = br_reg[sl.brsel];
									killed           = 1'h1;
								end
							end
							OP_RFI: begin
								if (qt && mode == ISA_NATIVE) begin
									next_mode        = save_mode;
									next_redirect    = 1'h1;
									next_redirect_pc = save_pc;
									killed           = 1'h1;
								end
							end
							OP_MOV_BR: begin
								if (qt && mode == ISA_NATIVE) begin
									next_br_we  = 1'h1;
									next_br_sel = sl.brsel;
									next_br_val = sl.addr;
								end
							end
							OP_JMP_NATIVE: begin
								if (mode == ISA_LEGACY) begin
									next_mode        = ISA_NATIVE;
									next_redirect    = 1'h1;
									next_redirect_pc = sl.addr;
									killed           = 1'h1;
								end
							end
						endcase
					end
				end
				if (bundle_used) begin
					next_issue = next_issue + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			mode <= psm_isa_t'(`PSM_RST_MODE);
		end else begin
			mode <= next_mode;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			pred <= `PSM_RST_PRED;
		end else begin
			pred <= next_pred;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			nat_gr <= '0;
			nat_fr <= '0;
		end else begin
			nat_gr <= next_nat_gr;
			nat_fr <= next_nat_fr;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			for (int i = 0; i < `PSM_BR_COUNT; i++) begin
				br_reg[i] <= `PSM_RST_ADDR;
			end
		end else if (next_br_we) begin
			br_reg[next_br_sel] <= next_br_val;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			save_pc   <= `PSM_RST_ADDR;
			save_mode <= psm_isa_t'(`PSM_RST_MODE);
		end else if (next_save_we) begin
			save_pc   <= next_save_pc;
			save_mode <= next_save_mode;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			for (int e = 0; e < `PSM_ALAT_ENTRIES; e++) begin
				alat_valid[e] <= 1'h0;
				alat_key[e]   <= '0;
				alat_addr[e]  <= `PSM_RST_ADDR;
			end
			alat_ptr <= '0;
		end else begin
			alat_valid <= next_alat_valid;
			alat_key   <= next_alat_key;
			alat_addr  <= next_alat_addr;
			alat_ptr   <= next_alat_ptr;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			NATIVE_MODE    <= 1'h1;
			REDIRECT_VALID <= 1'h0;
			REDIRECT_PC    <= `PSM_RST_ADDR;
			INT_ACK        <= 1'h0;
			ISSUE_COUNT    <= 2'h0;
			WB_EN          <= '0;
			MEM_REQ        <= '0;
			PRED           <= `PSM_RST_PRED;
		end else begin
			NATIVE_MODE    <= (next_mode == ISA_NATIVE);
			REDIRECT_VALID <= next_redirect;
			REDIRECT_PC    <= next_redirect_pc;
			INT_ACK        <= next_int_ack;
			ISSUE_COUNT    <= next_issue;
			WB_EN          <= next_wb;
			MEM_REQ        <= next_mem;
			PRED           <= next_pred;
		end
	end

endmodule : psm_ctl

//--- inc/psm_regs.svh
// constants for the predication, speculation and mode control block
`ifndef PSM_REGS_SVH
`define PSM_REGS_SVH

`define PSM_SLOTS          3
`define PSM_BUNDLES        2
`define PSM_GROUP_SLOTS    6
`define PSM_PR_COUNT       64
`define PSM_PR_IDX_W       6
`define PSM_GR_COUNT       128
`define PSM_FR_COUNT       128
`define PSM_REG_IDX_W      7
`define PSM_BR_COUNT       8
`define PSM_BR_IDX_W       3
`define PSM_HINT_W         2
`define PSM_ADDR_W         32
`define PSM_LINE_LSB       3
`define PSM_ALAT_ENTRIES   8
`define PSM_ALAT_IDX_W     3
`define PSM_RST_MODE       1'h0
`define PSM_RST_PRED       64'h0000_0000_0000_0001
`define PSM_RST_ADDR       32'h0000_0000

`endif

//--- inc/psm_pkg.sv
// types for the predication, speculation and mode control block
package psm_pkg;
`include "psm_regs.svh"

	typedef enum logic [0:0] {
		ISA_NATIVE = 1'h0,
		ISA_LEGACY = 1'h1
	} psm_isa_t;

	typedef enum logic [3:0] {
		OP_NOP        = 4'h0,
		OP_ALU        = 4'h1,
		OP_LD         = 4'h2,
		OP_LD_SPEC    = 4'h3,
		OP_LD_ADV     = 4'h4,
		OP_ST         = 4'h5,
		OP_CMP        = 4'h6,
		OP_CMP_UNC    = 4'h7,
		OP_CMP_AND    = 4'h8,
		OP_CMP_OR     = 4'h9,
		OP_CHK_S      = 4'hA,
		OP_CHK_A      = 4'hB,
		OP_BR_LEGACY  = 4'hC,
		OP_RFI        = 4'hD,
		OP_MOV_BR     = 4'hE,
		OP_JMP_NATIVE = 4'hF
	} psm_op_t;

	typedef struct packed {
		logic                        valid;
		psm_op_t                     op;
		logic [`PSM_PR_IDX_W-1:0]    qp;
		logic [`PSM_PR_IDX_W-1:0]    true_predicate;
		logic [`PSM_PR_IDX_W-1:0]    false_predicate;
		logic [`PSM_REG_IDX_W-1:0]   dst;
		logic                        fp;
		logic                        cond;
		logic                        fault;
		logic [`PSM_HINT_W-1:0]      hint;
		logic [`PSM_BR_IDX_W-1:0]    brsel;
		logic [`PSM_ADDR_W-1:0]      addr;
	} psm_slot_t;

	typedef struct packed {
		psm_slot_t [`PSM_SLOTS-1:0] slot;
	} psm_bundle_t;

	typedef struct packed {
		logic                   valid;
		logic                   store;
		logic [`PSM_HINT_W-1:0] hint;
		logic [`PSM_ADDR_W-1:0] addr;
	} psm_mem_req_t;

endpackage : psm_pkg

//--- tb/psm_ctl_sva.sv
// concurrent checks on the ports of the execution control block
`timescale 1ns/1ns
`include "psm_regs.svh"

module psm_ctl_sva
	import psm_pkg::*;
(
	input wire logic                           SYS_CLK,
	input wire logic                           RST,
	input wire logic                           GROUP_VALID,
	input wire logic [`PSM_ADDR_W-1:0]         GROUP_PC,
	input wire psm_bundle_t [`PSM_BUNDLES-1:0] GROUP,
	input wire logic                           INT_REQ,
	input wire logic [`PSM_ADDR_W-1:0]         INT_VECTOR,
	input wire logic                           NATIVE_MODE,
	input wire logic                           REDIRECT_VALID,
	input wire logic [`PSM_ADDR_W-1:0]         REDIRECT_PC,
	input wire logic                           INT_ACK,
	input wire logic [1:0]                     ISSUE_COUNT,
	input wire logic [`PSM_GROUP_SLOTS-1:0]    WB_EN,
	input wire psm_mem_req_t [`PSM_GROUP_SLOTS-1:0] MEM_REQ,
	input wire logic [`PSM_PR_COUNT-1:0]       PRED
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	a_int_entry_native: assert property (INT_REQ |=> INT_ACK && REDIRECT_VALID && NATIVE_MODE
		&& REDIRECT_PC == $past(INT_VECTOR)) else $error("interrupt entry wrong");
	a_int_discards_group: assert property (INT_REQ |=> WB_EN == '0 && !MEM_REQ[0].valid)
		else $error("interrupted group had effect");
	a_pred_zero_one: assert property (PRED[0]) else $error("predicate 0 not one");
	a_idle_no_effect: assert property (!GROUP_VALID && !INT_REQ |=> !REDIRECT_VALID && !INT_ACK
		&& WB_EN == '0 && ISSUE_COUNT == 2'h0) else $error("idle cycle had effect");
	a_mode_idle_hold: assert property (!GROUP_VALID && !INT_REQ |=> NATIVE_MODE ==
		$past(NATIVE_MODE)) else $error("mode moved while idle");
	a_mode_with_redirect: assert property ($changed(NATIVE_MODE) |-> REDIRECT_VALID)
		else $error("mode changed without transfer");
	a_legacy_one_slot: assert property (!NATIVE_MODE && GROUP_VALID && !INT_REQ |=>
		WB_EN[5:1] == 5'h00 && ISSUE_COUNT <= 2'h1) else $error("legacy used extra slots");
	a_issue_at_most: assert property (ISSUE_COUNT <= 2'h2) else $error("issue count too high");
	a_pc_only_redirect: assert property (!REDIRECT_VALID |-> REDIRECT_PC == '0)
		else $error("redirect pc without pulse");
	a_load_hint_kept: assert property (GROUP_VALID && !INT_REQ && NATIVE_MODE
		&& GROUP[0].slot[0].valid && GROUP[0].slot[0].op == OP_LD && GROUP[0].slot[0].qp == '0
		|=> MEM_REQ[0].valid && !MEM_REQ[0].store
		&& MEM_REQ[0].hint == $past(GROUP[0].slot[0].hint)) else $error("load hint lost");

	c_int_taken: cover property (INT_ACK);
	c_to_legacy: cover property ($fell(NATIVE_MODE));
	c_two_bundles: cover property (ISSUE_COUNT == 2'h2);
endmodule : psm_ctl_sva

bind psm_ctl psm_ctl_sva u_sva (.SYS_CLK(SYS_CLK), .RST(RST), .GROUP_VALID(GROUP_VALID),
	.GROUP_PC(GROUP_PC), .GROUP(GROUP), .INT_REQ(INT_REQ), .INT_VECTOR(INT_VECTOR),
	.NATIVE_MODE(NATIVE_MODE), .REDIRECT_VALID(REDIRECT_VALID), .REDIRECT_PC(REDIRECT_PC),
	.INT_ACK(INT_ACK), .ISSUE_COUNT(ISSUE_COUNT), .WB_EN(WB_EN), .MEM_REQ(MEM_REQ), .PRED(PRED));

//--- tb/psm_src.sv
// instruction stream source: presents issue groups and interrupt requests
`timescale 1ns/1ns
`include "psm_regs.svh"

module psm_src
	import psm_pkg::*;
(
	input  wire logic                          SYS_CLK,
	output logic                               GROUP_VALID,
	output logic [`PSM_ADDR_W-1:0]             GROUP_PC,
	output psm_bundle_t [`PSM_BUNDLES-1:0]     GROUP,
	output logic                               INT_REQ,
	output logic [`PSM_ADDR_W-1:0]             INT_VECTOR
);
	initial begin
		GROUP_VALID = 1'b0;
		INT_REQ = 1'b0;
		GROUP_PC = '1;
		GROUP = '1;
		INT_VECTOR = '1;
	end

	// one group of three-slot bundles for one cycle, vector derived from pc
	task automatic send(input logic irq, input logic [`PSM_ADDR_W-1:0] pc,
		input psm_bundle_t [`PSM_BUNDLES-1:0] g);
		@(posedge SYS_CLK);
		GROUP_VALID <= 1'b1;
		INT_REQ <= irq;
		GROUP_PC <= pc;
		GROUP <= g;
		INT_VECTOR <= pc + 32'h0000_1000;
		@(posedge SYS_CLK);
		// released lines show the inverse so stale values cannot pass for live ones
		GROUP_VALID <= 1'b0;
		INT_REQ <= 1'b0;
		GROUP_PC <= ~pc;
		GROUP <= ~g;
		INT_VECTOR <= ~(pc + 32'h0000_1000);
	endtask : send
endmodule : psm_src

//--- tb/psm_ctl_test.sv
// self-checking testbench for the execution control block
`timescale 1ns/1ns
`include "psm_regs.svh"

module psm_ctl_test
	import psm_pkg::*;
;
	logic                           SYS_CLK;
	logic                           RST;
	logic                           GROUP_VALID;
	logic [`PSM_ADDR_W-1:0]         GROUP_PC;
	psm_bundle_t [`PSM_BUNDLES-1:0] GROUP;
	logic                           INT_REQ;
	logic [`PSM_ADDR_W-1:0]         INT_VECTOR;
	logic                           NATIVE_MODE;
	logic                           REDIRECT_VALID;
	logic [`PSM_ADDR_W-1:0]         REDIRECT_PC;
	logic                           INT_ACK;
	logic [1:0]                     ISSUE_COUNT;
	logic [`PSM_GROUP_SLOTS-1:0]    WB_EN;
	psm_mem_req_t [`PSM_GROUP_SLOTS-1:0] MEM_REQ;
	logic [`PSM_PR_COUNT-1:0]       PRED;
	int                             n_mismatch;
	int                             check_count;

	psm_src u_src (.SYS_CLK(SYS_CLK), .GROUP_VALID(GROUP_VALID), .GROUP_PC(GROUP_PC),
		.GROUP(GROUP), .INT_REQ(INT_REQ), .INT_VECTOR(INT_VECTOR));
	psm_ctl u_dut (.SYS_CLK(SYS_CLK), .RST(RST), .GROUP_VALID(GROUP_VALID), .GROUP_PC(GROUP_PC),
		.GROUP(GROUP), .INT_REQ(INT_REQ), .INT_VECTOR(INT_VECTOR), .NATIVE_MODE(NATIVE_MODE),
		.REDIRECT_VALID(REDIRECT_VALID), .REDIRECT_PC(REDIRECT_PC), .INT_ACK(INT_ACK),
		.ISSUE_COUNT(ISSUE_COUNT), .WB_EN(WB_EN), .MEM_REQ(MEM_REQ), .PRED(PRED));

	initial begin
		SYS_CLK = 1'b0;
		forever #50 SYS_CLK = ~SYS_CLK;
	end

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic psm_slot_t sl(psm_op_t op, logic [5:0] qp, logic [6:0] dst,
		logic [31:0] addr);
		psm_slot_t s;
		s = '0;
		s.valid = 1'b1;
		s.op = op;
		s.qp = qp;
		s.dst = dst;
		s.addr = addr;
		return s;
	endfunction : sl

	function automatic psm_slot_t cm(psm_op_t op, logic [5:0] qp, logic [5:0] tp,
		logic [5:0] fp, logic cond);
		psm_slot_t s;
		s = sl(op, qp, 7'h00, 32'h0000_0000);
		s.true_predicate = tp;
		s.false_predicate = fp;
		s.cond = cond;
		return s;
	endfunction : cm

	// outputs settle one time unit after the taking edge
	task automatic run(input logic irq, input logic [31:0] pc, input psm_bundle_t [1:0] g);
		u_src.send(irq, pc, g);
		#1;
	endtask : run

	task automatic run1(input psm_slot_t s);
		psm_bundle_t [1:0] g;
		g = '0;
		g[0].slot[0] = s;
		run(1'b0, 32'h0000_0010, g);
	endtask : run1

	task automatic t_reset;
		chk(NATIVE_MODE, 1'b1);
		chk(PRED, `PSM_RST_PRED);
		chk({REDIRECT_VALID, INT_ACK, WB_EN}, 8'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic t_cmp;
		logic [63:0] ep;
		psm_bundle_t [1:0] g;
		ep = `PSM_RST_PRED;
		run1(cm(OP_CMP, 6'h00, 6'h05, 6'h06, 1'b1));
		ep[6:5] = 2'h1;
		chk(PRED, ep);
		run1(cm(OP_CMP, 6'h00, 6'h05, 6'h06, 1'b0));
		ep[6:5] = 2'h2;
		chk(PRED, ep);
		run1(cm(OP_CMP, 6'h00, 6'h07, 6'h08, 1'b1));
		run1(cm(OP_CMP_UNC, 6'h05, 6'h07, 6'h08, 1'b1));
		chk(PRED, ep);
		run1(cm(OP_CMP_OR, 6'h00, 6'h07, 6'h08, 1'b1));
		ep[8:7] = 2'h3;
		chk(PRED, ep);
		run1(cm(OP_CMP_AND, 6'h00, 6'h07, 6'h08, 1'b0));
		ep[8:7] = 2'h0;
		chk(PRED, ep);
		run1(cm(OP_CMP, 6'h00, 6'h00, 6'h09, 1'b0));
		ep[9] = 1'b1;
		chk(PRED, ep);
		g = '0;
		g[0].slot[0] = sl(OP_ALU, 6'h06, 7'h01, 32'h0000_0000);
		g[0].slot[1] = sl(OP_ALU, 6'h05, 7'h02, 32'h0000_0000);
		g[1].slot[2] = sl(OP_LD, 6'h00, 7'h03, 32'h0000_0040);
		g[1].slot[2].hint = 2'h3;
		run(1'b0, 32'h0000_0020, g);
		chk(WB_EN, 6'h21);
		chk(ISSUE_COUNT, 2'h2);
		chk({MEM_REQ[5].valid, MEM_REQ[5].hint, MEM_REQ[5].addr}, 35'h7_0000_0040);
		chk(PRED, ep);
		$display("test compare done");
	endtask : t_cmp

	task automatic t_spec;
		psm_slot_t s;
		s = sl(OP_LD_SPEC, 6'h00, 7'h09, 32'h0000_0080);
		s.fault = 1'b1;
		run1(s);
		chk({REDIRECT_VALID, WB_EN[0], MEM_REQ[0].valid}, 3'h3);
		run1(sl(OP_CHK_S, 6'h00, 7'h09, 32'h0000_0A00));
		chk({REDIRECT_VALID, REDIRECT_PC}, 33'h1_0000_0A00);
		run1(sl(OP_LD, 6'h00, 7'h09, 32'h0000_0080));
		run1(sl(OP_CHK_S, 6'h00, 7'h09, 32'h0000_0A00));
		chk({REDIRECT_VALID, WB_EN}, 7'h00);
		$display("test control speculation done");
	endtask : t_spec

	task automatic t_adv;
		run1(sl(OP_LD_ADV, 6'h00, 7'h14, 32'h0000_0100));
		run1(sl(OP_CHK_A, 6'h00, 7'h14, 32'h0000_0200));
		chk(REDIRECT_VALID, 1'b0);
		run1(sl(OP_ST, 6'h00, 7'h00, 32'h0000_0104));
		chk({MEM_REQ[0].valid, MEM_REQ[0].store}, 2'h3);
		run1(sl(OP_CHK_A, 6'h00, 7'h14, 32'h0000_0200));
		chk({REDIRECT_VALID, REDIRECT_PC}, 33'h1_0000_0200);
		$display("test data speculation done");
	endtask : t_adv

	task automatic t_mode;
		psm_slot_t s;
		psm_bundle_t [1:0] g;
		s = sl(OP_MOV_BR, 6'h00, 7'h00, 32'h0000_8000);
		s.brsel = 3'h2;
		run1(s);
		s = sl(OP_BR_LEGACY, 6'h00, 7'h00, 32'h0000_0000);
		s.brsel = 3'h2;
		run1(s);
		chk({REDIRECT_VALID, REDIRECT_PC, NATIVE_MODE}, 34'h2_0001_0000);
		run1(cm(OP_CMP, 6'h00, 6'h0B, 6'h0C, 1'b1));
		chk({PRED[11], NATIVE_MODE}, 2'h0);
		g = '0;
		g[0].slot[0] = sl(OP_ALU, 6'h00, 7'h01, 32'h0000_0000);
		run(1'b1, 32'h0000_3000, g);
		chk({INT_ACK, REDIRECT_PC, NATIVE_MODE, WB_EN}, 40'h80_0020_0040);
		run1(sl(OP_RFI, 6'h00, 7'h00, 32'h0000_0000));
		chk({REDIRECT_VALID, REDIRECT_PC, NATIVE_MODE}, 34'h2_0000_6000);
		run1(sl(OP_JMP_NATIVE, 6'h00, 7'h00, 32'h0000_5000));
		chk({REDIRECT_VALID, REDIRECT_PC, NATIVE_MODE}, 34'h2_0000_A001);
		$display("test mode transitions done");
	endtask : t_mode

	initial begin
		n_mismatch = 0;
		check_count = 0;
		RST = 1'b1;
		repeat (4) @(posedge SYS_CLK);
		RST <= 1'b0;
		@(posedge SYS_CLK);
		#1;
		t_reset;
		t_cmp;
		t_spec;
		t_adv;
		t_mode;
		print_verdict;
	end

	// the whole run takes about fifty cycles
	initial begin
		repeat (2000) @(posedge SYS_CLK);
		n_mismatch++;
		print_verdict;
	end
endmodule : psm_ctl_test
